// ---- pled_sequencer.sv ----
// power led blink sequencer: request arbitration and pattern timing
// Operation
// R1 - S0 holds primary colour steadily lit
// R2 - S0 indication enabled by default, can disable
// R3 - S3 blinks alternate colour 250/250 ms
// R4 - standby blink default, setting selects alternative
// R5 - ready mode blinks primary 1 s/1 s
// R6 - update: off first, then 0.5 s blinks
// R7 - memory error: three 1 s blinks, 2.5 s pause
// R8 - thermal: 16 blinks of 250 ms, stop
// R9 - firmware requests error pattern, device shows it
// R10 - faults over update over state; restart pattern
`default_nettype none
module pled_sequencer #(
    // clock cycles per millisecond tick; shorter values speed up simulation
    parameter int unsigned TICK_LEN = pled_pkg::TICK_CYCLES
) (
    // clock and reset
    input  wire logic       clk_sys_i,
    input  wire logic       rst_n_i,
    // configuration
    input  wire logic       s0_led_dis_i,
    input  wire logic [1:0] stby_mode_i,
    // state and fault requests (pin levels)
    input  wire logic       req_s0_i,
    input  wire logic       req_s3_i,
    input  wire logic       req_ready_i,
    input  wire logic       req_fwu_i,
    input  wire logic       req_mem_i,
    input  wire logic       req_therm_i,
    // led driver
    output logic            led_pri_o,
    output logic            led_alt_o,
    output logic            therm_done_o
);
    import pled_pkg::*;

    // three-stage synchronisers for the six request pins
    logic [5:0] raw;
    logic [5:0] sy1;
    logic [5:0] sy2;
    logic [5:0] sy3;
    logic [5:0] req;
    logic [5:0] next_req;
    assign raw = {req_therm_i, req_mem_i, req_fwu_i, req_ready_i, req_s3_i, req_s0_i};

    // per-bit sync chain; a change counts once stages two and three agree
    genvar g;
    generate
        for (g = 0; g < 6; g++) begin : g_sync
            always_comb begin
                next_req[g] = (sy2[g] == sy3[g]) ? sy3[g] : req[g];
            end
            always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
                if (!rst_n_i) begin
                    sy1[g] <= 1'b0;
                    sy2[g] <= 1'b0;
                    sy3[g] <= 1'b0;
                    req[g] <= 1'b0;
                end else begin
                    sy1[g] <= raw[g];
                    sy2[g] <= sy1[g];
                    sy3[g] <= sy2[g];
                    req[g] <= next_req[g];
                end
            end
        end
    endgenerate

    // requested pattern by priority
    pled_pat_e sel;
    always_comb begin
        // R10 priority select
        if (req[5]) begin
            sel = PLED_THERM;
        end else if (req[4]) begin
            sel = PLED_MEM;
        end else if (req[3]) begin
            sel = PLED_FWU;
        end else if (req[2]) begin
            sel = PLED_READY;
        end else if (req[1]) begin
            sel = PLED_S3;
        end else if (req[0]) begin
            sel = PLED_S0;
        end else begin
            sel = PLED_OFF;
        end
    end

    pled_pat_e        pat;
    pled_pat_e        next_pat;
    logic [MS_W-1:0]  ms;
    logic [MS_W-1:0]  next_ms;
    logic [CNT_W-1:0] blinks;
    logic [CNT_W-1:0] next_blinks;
    logic             lit;
    logic             next_lit;
    logic             pri;
    logic             next_pri;
    logic             alt;
    logic             next_alt;
    logic             change;
    logic             tick;

    // thermal pattern held done until its request drops
    assign change = (sel != pat) && !(pat == PLED_DONE && sel == PLED_THERM);

    // millisecond tick, realigned when a pattern starts
    pled_prescaler #(.TICK_LEN(TICK_LEN)) u_pre (
        .clk_sys_i (clk_sys_i),
        .rst_n_i   (rst_n_i),
        .restart_i (change),
        .tick_o    (tick)
    );

    // pattern sequencer next state
    always_comb begin
        next_pat    = pat;
        next_ms     = ms;
        next_blinks = blinks;
        next_lit    = lit;
        if (change) begin
            // R10 restart first phase
            next_pat    = sel;
            next_ms     = '0;
            next_blinks = '0;
            // R6 update starts dark
            next_lit    = (sel != PLED_FWU) && (sel != PLED_OFF);
        end else if (tick) begin
            next_ms = ms + MS_W'(1);
            case (pat)
                PLED_S3: begin
                    // R3 quarter second phases
                    if (ms == MS_W'(S3_PHASE_MS - 1)) begin
                        next_ms  = '0;
                        next_lit = !lit;
                    end
                end
                PLED_READY: begin
                    // R5 one second phases
                    if (ms == MS_W'(READY_PHASE_MS - 1)) begin
                        next_ms  = '0;
                        next_lit = !lit;
                    end
                end
                PLED_FWU: begin
                    // R6 half second phases
                    if (ms == MS_W'(FWU_PHASE_MS - 1)) begin
                        next_ms  = '0;
                        next_lit = !lit;
                    end
                end
                PLED_MEM: begin
                    // R7 three blinks then pause, repeat
                    if (blinks == CNT_W'(MEM_BLINKS)) begin
                        if (ms == MS_W'(MEM_PAUSE_MS - 1)) begin
                            next_ms     = '0;
                            next_blinks = '0;
                            next_lit    = 1'b1;
                        end
                    end else if (ms == MS_W'(MEM_PHASE_MS - 1)) begin
                        next_ms  = '0;
                        next_lit = !lit;
                        if (!lit) begin
                            next_lit = (blinks != CNT_W'(MEM_BLINKS - 1));
                        end
                        if (!lit) begin
                            next_blinks = blinks + CNT_W'(1);
                        end
                    end
                end
                PLED_THERM: begin
                    // R8 sixteen blinks then stop
                    if (ms == MS_W'(THERM_PHASE_MS - 1)) begin
                        next_ms  = '0;
                        next_lit = !lit;
                        if (!lit) begin
                            next_blinks = blinks + CNT_W'(1);
                            if (blinks == CNT_W'(THERM_BLINKS - 1)) begin
                                next_pat = PLED_DONE;
                                next_lit = 1'b0;
                            end
                        end
                    end
                end
                default: begin
                    next_ms = '0;
                end
            endcase
        end
    end

    // colour outputs from the current phase
    always_comb begin
        next_pri = 1'b0;
        next_alt = 1'b0;
        case (next_pat)
            // R1 R2 steady primary unless disabled
            PLED_S0: next_pri = !s0_led_dis_i;
            PLED_S3: begin
                // R4 standby behaviour selection
                case (stby_mode_i)
                    STBY_STEADY: next_alt = 1'b1;
                    STBY_DARK:   next_alt = 1'b0;
                    default:     next_alt = next_lit;
                endcase
            end
            // R9 error patterns shown on request
            PLED_READY, PLED_FWU, PLED_MEM, PLED_THERM: next_pri = next_lit;
            default: next_pri = 1'b0;
        endcase
    end

    // register sequencer state
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pat    <= PLED_OFF;
            ms     <= '0;
            blinks <= '0;
            lit    <= 1'b0;
            pri    <= 1'b0;
            alt    <= 1'b0;
        end else begin
            pat    <= next_pat;
            ms     <= next_ms;
            blinks <= next_blinks;
            lit    <= next_lit;
            pri    <= next_pri;
            alt    <= next_alt;
        end
    end

    assign led_pri_o    = pri;
    assign led_alt_o    = alt;
    assign therm_done_o = (pat == PLED_DONE);

    // a_colour_excl: never both colours
    a_colour_excl: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        !(led_pri_o && led_alt_o)) else $error("both colours lit");
    a_s0_steady: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // R1
        (pat == PLED_S0 && $past(pat) == PLED_S0 && !$past(s0_led_dis_i)) |-> led_pri_o)
        else $error("s0 not lit");
    a_s0_disable: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // R2
        (pat == PLED_S0 && s0_led_dis_i) |=> (!led_pri_o || pat != PLED_S0))
        else $error("s0 lit while disabled");
    a_s3_phase: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // R3
        (pat == PLED_S3 && tick && ms == MS_W'(S3_PHASE_MS - 1) && !change) |=> lit != $past(lit))
        else $error("s3 phase not toggled");
    a_s3_alt: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // R4
        (pat == PLED_S3 && $past(pat) == PLED_S3 && stby_mode_i == STBY_BLINK
         && $past(stby_mode_i) == STBY_BLINK) |-> (led_alt_o == lit && !led_pri_o))
        else $error("s3 colour wrong");
    a_ready_hold: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // R5
        (pat == PLED_READY && tick && ms != MS_W'(READY_PHASE_MS - 1) && !change) |=> $stable(lit))
        else $error("ready toggled early");
    a_fwu_dark: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // R6
        (change && sel == PLED_FWU) |=> !led_pri_o)
        else $error("update not dark first");
    a_mem_pause: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // R7
        (pat == PLED_MEM && blinks == CNT_W'(MEM_BLINKS)) |-> !lit)
        else $error("lit in pause");
    a_therm_stop: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // R8
        (pat == PLED_DONE) |-> !led_pri_o) else $error("lit after thermal");
    a_prio_restart: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // R10
        change |=> (pat == $past(sel) && ms == '0 && blinks == '0))
        else $error("pattern not restarted");
endmodule // pled_sequencer
`default_nettype wire

// ---- pled_pkg.sv ----
// package: constants and types for the power led blink sequencer
`default_nettype none
package pled_pkg;
    // clock rate and derived tick (1 ms enable from prescaler)
    localparam int unsigned CLK_HZ        = 40_000_000;
    localparam int unsigned TICK_US       = 1000;
    localparam int unsigned TICK_CYCLES   = CLK_HZ / 1_000_000 * TICK_US;
    localparam int unsigned PRE_W         = 16;
    // pattern phase times in milliseconds (ticks)
    localparam int unsigned S3_PHASE_MS   = 250;
    localparam int unsigned READY_PHASE_MS = 1000;
    localparam int unsigned FWU_PHASE_MS  = 500;
    localparam int unsigned MEM_PHASE_MS  = 1000;
    localparam int unsigned MEM_PAUSE_MS  = 2500;
    localparam int unsigned THERM_PHASE_MS = 250;
    localparam int unsigned THERM_BLINKS  = 16;
    localparam int unsigned MEM_BLINKS    = 3;
    localparam int unsigned MS_W          = 12;
    localparam int unsigned CNT_W         = 5;
    // standby behaviour codes: alternate colour blinking, steady or dark
    localparam logic [1:0] STBY_BLINK     = 2'h0;
    localparam logic [1:0] STBY_STEADY    = 2'h1;
    localparam logic [1:0] STBY_DARK      = 2'h2;

    // active pattern, one-hot
    typedef enum logic [7:0] {
        PLED_OFF   = 8'h01,
        PLED_S0    = 8'h02,
        PLED_S3    = 8'h04,
        PLED_READY = 8'h08,
        PLED_FWU   = 8'h10,
        PLED_MEM   = 8'h20,
        PLED_THERM = 8'h40,
        PLED_DONE  = 8'h80
    } pled_pat_e;
endpackage : pled_pkg
`default_nettype wire

// ---- pled_prescaler.sv ----
// prescaler: one-cycle enable pulse every tick period
`default_nettype none
module pled_prescaler #(
    // clock cycles per tick; shorter values speed up simulation
    parameter int unsigned TICK_LEN = pled_pkg::TICK_CYCLES
) (
    // clock and reset
    input  wire logic clk_sys_i,
    input  wire logic rst_n_i,
    // restart and tick
    input  wire logic restart_i,
    output logic      tick_o
);
    import pled_pkg::*;

    localparam logic [PRE_W-1:0] TOP = PRE_W'(TICK_LEN - 1);

    logic [PRE_W-1:0] cnt;
    logic [PRE_W-1:0] next_cnt;

    // next count, wraps at the tick period
    always_comb begin
        if (restart_i || cnt == TOP) begin
            next_cnt = '0;
        end else begin
            next_cnt = cnt + PRE_W'(1);
        end
    end

    // register count
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cnt <= '0;
        end else begin
            cnt <= next_cnt;
        end
    end

    assign tick_o = (cnt == TOP) && !restart_i;
endmodule // pled_prescaler
`default_nettype wire

// ---- pled_led_model.sv ----
// model of the bicolour power led driver on the far side of the block
`default_nettype none
module pled_led_model (
    // clock
    input  wire logic       clk_sys_i,
    // led driver inputs
    input  wire logic       led_pri_i,
    input  wire logic       led_alt_i,
    // observed light: bit 0 primary die, bit 1 alternate die
    output logic [1:0]      colour_o,
    output logic            clash_o
);
    timeunit 1ns;
    timeprecision 1ps;

    // light seen by the viewer
    assign colour_o = {led_alt_i, led_pri_i};

    // both dies lit at once would mix the colours; latch it for the bench
    always @(posedge clk_sys_i) begin
        clash_o <= (clash_o === 1'b1) || (led_pri_i === 1'b1 && led_alt_i === 1'b1);
    end
endmodule // pled_led_model
`default_nettype wire

// ---- testbench.sv ----
// self-checking testbench for the power led blink sequencer
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import pled_pkg::*;

    localparam logic [1:0] DARK = 2'h0;
    localparam logic [1:0] PRI  = 2'h1;
    localparam logic [1:0] ALT  = 2'h2;

    // shortened tick for simulation and the phase lengths it gives
    localparam int unsigned TB_TICK = 2;
    localparam int S3_T    = int'(S3_PHASE_MS * TB_TICK);
    localparam int RDY_T   = int'(READY_PHASE_MS * TB_TICK);
    localparam int FWU_T   = int'(FWU_PHASE_MS * TB_TICK);
    localparam int MEM_T   = int'(MEM_PHASE_MS * TB_TICK);
    localparam int PAUSE_T = int'(MEM_PAUSE_MS * TB_TICK);
    localparam int THERM_T = int'(THERM_PHASE_MS * TB_TICK);
    // set_req returns this many clock edges after the pattern restarts
    localparam int LEAD    = 7;

    // stimulus and observation
    logic       clk_sys_i    = 1'b0;
    logic       rst_n_i      = 1'b0;
    logic       s0_led_dis   = 1'b0;
    logic [1:0] stby_mode    = STBY_BLINK;
    logic [5:0] req          = 6'h00;
    logic       led_pri;
    logic       led_alt;
    logic       therm_done;
    logic [1:0] colour;
    logic       clash;
    int         error_cnt    = 0;
    int         compares     = 0;

    // 40 MHz system clock
    always #12.5 clk_sys_i = ~clk_sys_i;

    pled_sequencer #(.TICK_LEN(TB_TICK)) uut (
        .clk_sys_i    (clk_sys_i),
        .rst_n_i      (rst_n_i),
        .s0_led_dis_i (s0_led_dis),
        .stby_mode_i  (stby_mode),
        .req_s0_i     (req[0]),
        .req_s3_i     (req[1]),
        .req_ready_i  (req[2]),
        .req_fwu_i    (req[3]),
        .req_mem_i    (req[4]),
        .req_therm_i  (req[5]),
        .led_pri_o    (led_pri),
        .led_alt_o    (led_alt),
        .therm_done_o (therm_done)
    );

    pled_led_model led_model (
        .clk_sys_i (clk_sys_i),
        .led_pri_i (led_pri),
        .led_alt_i (led_alt),
        .colour_o  (colour),
        .clash_o   (clash)
    );

    // print the verdict and end the run
    task automatic stop_test();
        $display("compares=%0d error_cnt=%0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // light must hold the expected colour for n cycles; n may be a whole phase length
    task automatic check_led(input logic [1:0] exp, input int n);
        int k;
        for (k = 0; k < n; k++) begin
            @(negedge clk_sys_i);
            compares++;
            if (colour !== exp || clash !== 1'b0) begin
                error_cnt++;
                $display("BAD %0t led %b expected %b", $time, colour, exp);
                break;
            end
        end
    endtask

    // lit phase then dark phase, n times, right after set_req; exact edges
    task automatic check_blink(input logic [1:0] on_c, input int ph, input int n);
        int b;
        check_led(on_c, ph - LEAD - 1);
        for (b = 0; b < n; b++) begin
            if (b > 0) begin
                check_led(on_c, ph);
            end
            check_led(DARK, ph);
        end
    endtask

    // drive request pins and let the synchroniser and output register settle
    task automatic set_req(input logic [5:0] r);
        @(negedge clk_sys_i);
        req = r;
        repeat (12) @(negedge clk_sys_i);
    endtask

    // steady primary in s0, dark when the setting disables it
    task automatic t_s0();
        set_req(6'h01);
        check_led(PRI, 1000);
        s0_led_dis = 1'b1;
        repeat (4) @(negedge clk_sys_i);
        check_led(DARK, 1000);
        s0_led_dis = 1'b0;
        repeat (4) @(negedge clk_sys_i);
        check_led(PRI, 200);
    endtask

    // every standby behaviour; blink starts with its lit alternate phase
    task automatic t_stby();
        logic [1:0] exp_tab [4];
        logic [1:0] exp_off [4];
        int m;
        exp_tab = '{ALT, ALT, DARK, ALT};
        exp_off = '{DARK, ALT, DARK, DARK};
        for (m = 0; m < 4; m++) begin
            set_req(6'h00);
            stby_mode = m[1:0];
            set_req(6'h02);
            check_led(exp_tab[m], S3_T - LEAD - 1);
            check_led(exp_off[m], S3_T);
            check_led(exp_tab[m], 20);
        end
        stby_mode = STBY_BLINK;
    endtask

    // ready mode: primary 1 s on, 1 s off
    task automatic t_ready();
        set_req(6'h04);
        check_blink(PRI, RDY_T, 1);
        check_led(PRI, 20);
    endtask

    // update over state: dark first, then half-second primary blinks
    task automatic t_fwu();
        set_req(6'h0D);
        check_led(DARK, FWU_T - LEAD - 1);
        check_led(PRI, FWU_T);
        check_led(DARK, FWU_T);
        check_led(PRI, 20);
    endtask

    // memory error over update: three blinks, pause, group repeats
    task automatic t_mem();
        set_req(6'h1D);
        check_blink(PRI, MEM_T, int'(MEM_BLINKS));
        check_led(DARK, PAUSE_T);
        check_led(PRI, 20);
    endtask

    // thermal over all: sixteen blinks, then dark with done raised
    task automatic t_therm();
        set_req(6'h3F);
        compares++;
        if (therm_done !== 1'b0) begin
            error_cnt++;
            $display("BAD %0t thermal done raised early", $time);
        end
        check_blink(PRI, THERM_T, int'(THERM_BLINKS));
        check_led(DARK, 20);
        compares++;
        if (therm_done !== 1'b1) begin
            error_cnt++;
            $display("BAD %0t thermal done missing", $time);
        end
    endtask

    // dropping requests restarts the next pattern from its first phase
    task automatic t_release();
        set_req(6'h1F);
        compares++;
        if (therm_done !== 1'b0) begin
            error_cnt++;
            $display("BAD %0t thermal done held", $time);
        end
        check_led(PRI, 20);
        set_req(6'h0C);
        check_led(DARK, 20);
        set_req(6'h00);
        check_led(DARK, 500);
    endtask

    // main sequence
    initial begin
        repeat (5) @(negedge clk_sys_i);
        check_led(DARK, 1);
        rst_n_i = 1'b1;
        t_s0();
        t_stby();
        t_ready();
        t_fwu();
        t_mem();
        t_therm();
        t_release();
        stop_test();
    end

    // watchdog: tests need about 47000 cycles
    initial begin
        #(80_000 * 25);
        error_cnt++;
        $display("BAD %0t watchdog expired", $time);
        stop_test();
    end
endmodule // testbench
`default_nettype wire
